// ==== design/dcgc_pkg.sv ====
// Constants shared by the acquisition controller and its checks
package dcgc_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ    = 25;      // Clock rate in MHz
  localparam int unsigned SAMPLE_NS  = 1000;    // Start-to-start sample spacing within a scan
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RATE_US    = 1000;    // Least period between scans
  localparam int unsigned RATE_W     = 20;      // Width of the rate counter
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;      // Conversion control
  localparam logic [7:0] A_STAT   = 8'h04;      // Status, overflow clear
  localparam logic [7:0] A_FIFO   = 8'h08;      // Sample queue head, pops
  localparam logic [7:0] A_DAC0   = 8'h0C;      // Analog output 0 code
  localparam logic [7:0] A_DAC1   = 8'h10;      // Analog output 1 code
  localparam logic [7:0] A_DIR    = 8'h14;      // Line directions, 1 = out
  localparam logic [7:0] A_OUT    = 8'h18;      // Line output levels
  localparam logic [7:0] A_IN     = 8'h1C;      // Line levels, both ports
  localparam logic [7:0] A_LINE   = 8'h20;      // Single line access
  localparam logic [7:0] A_PERIPH = 8'h24;      // Board peripheral controls
  localparam logic [7:0] A_SUPPLY = 8'h28;      // Scaled rail reading
  localparam logic [7:0] A_TEMP   = 8'h2C;      // Die temperature
  localparam logic [7:0] A_THRESH = 8'h30;      // Chunk level of the queue
  // Control field positions
  localparam int unsigned CTRL_GO    = 0;       // Request a conversion
  localparam int unsigned CTRL_DIFF  = 1;       // Pair mode
  localparam int unsigned CTRL_SCAN  = 2;       // Scan first..last
  localparam int unsigned CTRL_CONT  = 3;       // Repeat at the rate limit
  localparam int unsigned CTRL_FIRST = 4;       // First channel, 4 bits
  localparam int unsigned CTRL_LAST  = 8;       // Last channel, 4 bits
  localparam int unsigned CTRL_AVG   = 12;      // log2 of samples, 3 bits
  localparam int unsigned LINE_VAL   = 8;       // Level bit of a line write
  // Channel layout
  localparam logic [3:0] SUPPLY_BASE = 4'h6;    // First rail channel
  localparam logic [2:0] AVG_MAX     = 3'h4;    // Sixteen samples at most
  localparam logic [12:0] CODE_MAX   = 13'h0FFF; // Largest 12-bit code
  // Rail scale factors in thousandths
  localparam logic [12:0] SCALE_5V0  = 13'h07D0; // 2.000
  localparam logic [12:0] SCALE_MAIN = 13'h1595; // 5.525
  localparam logic [12:0] SCALE_1V8  = 13'h03E8; // 1.000
  localparam logic [12:0] SCALE_3V3  = 13'h07D0; // 2.000
  // Widths and reset values
  localparam int unsigned NUM_LINES  = 13;      // Port A 8 lines, B 5 lines
  localparam int unsigned PORTA_W    = 8;       // Lines A0..A7
  localparam int unsigned FIFO_AW    = 4;       // Queue index width
  localparam int unsigned SAMPLE_W   = 16;      // Queue word width
  localparam logic [9:0]  PERIPH_RST = 10'h010; // 1.2 V camera rail off
  localparam logic [4:0]  THRESH_RST = 5'h08;   // Chunk of eight samples
endpackage

// ==== design/dcgc_top.sv ====
// Acquisition controller: converter sequencer, sample queue, lines, controls
// Operation
// - Host exchanges all commands and data over link
// - Six single inputs or three pairs, 12-bit
// - Input code clamped between 0 and 4095
// - Pair result is high minus low channel
// - Negative pair result saturates at code zero
// - Single channel or consecutive channel scan
// - Scan samples spaced about one microsecond apart
// - Samples queued and delivered in chunks
// - Continuous acquisition serviced without per-sample polling
// - Averaging extends resolution up to 16 bits
// - Scan start rate at most one kilohertz
// - Two analog outputs set by 12-bit codes
// - Output codes range from 0 to 4095
// - All thirteen lines are inputs after reset
// - Every line has its own direction
// - Port A eight lines, port B five
// - Lines accessed singly, or read both ports together
// - Four rail channels with per-rail scale
// - Rail scales 2.0, 5.525, 1.0, 2.0
// - Die temperature reported in degrees Celsius
// - User LED on a software-switched line
// - Drive fan, modem, display, camera, serial controls
// - Camera 1.2 V enable low, others high
`timescale 1ns/100ps
module dcgc_top
  import dcgc_pkg::*;
#(
  parameter int unsigned RATE_CYC = RATE_US * CLK_MHZ
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      conv_start,
  output logic      [3:0]           conv_chan,
  input  wire logic                 conv_done,
  input  wire logic [12:0]          conv_data,
  output logic      [11:0]          dac0_code,
  output logic      [11:0]          dac1_code,
  input  wire logic [NUM_LINES-1:0] gpio_in,
  output logic      [NUM_LINES-1:0] gpio_out,
  output logic      [NUM_LINES-1:0] gpio_oe,
  input  wire logic [7:0]           temp_c,
  output logic                      led_on,
  output logic                      fan_en,
  output logic                      modem_en,
  output logic                      disp5v_en,
  output logic                      cam12_en_n,
  output logic                      cam18_en,
  output logic                      cam28_en,
  output logic      [1:0]           serial_cfg,
  output logic                      serial_slew,
  output logic                      chunk_ready
);

  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_GAP  = 4'b0010,
    S_CONV = 4'b0100,
    S_WAIT = 4'b1000
  } dcgc_state_e;

  localparam int unsigned DEPTH = 1 << FIFO_AW;   // Queue depth

  dcgc_state_e          state_q;     // Sequencer state
  logic                 ack_q;       // Second cycle of a bus request
  logic                 do_wr;       // Write takes effect this edge
  logic                 do_rd;       // Read completes this edge
  logic [31:0]          rd_mux;      // Read data selected by address
  logic [31:0]          rdata_q;     // Registered read data
  logic [15:0]          ctrl_q;      // Conversion control fields
  logic                 go_q;        // Pending conversion request
  logic                 diff_q;      // Mode latched at scan start
  logic                 cont_q;      // Continuous mode latched
  logic [3:0]           chan_q;      // Current channel or pair
  logic [3:0]           last_q;      // Last channel of the scan
  logic [2:0]           avg_q;       // log2 of averaged samples
  logic [3:0]           rep_q;       // Sample count within an average
  logic                 ph_lo_q;     // Pair low side being converted
  logic [11:0]          hi_q;        // Pair high side code
  logic [SAMPLE_W-1:0]  acc_q;       // Averaging sum
  logic [4:0]           gap_q;       // Spacing counter
  logic [RATE_W-1:0]    rate_q;      // Scan rate counter
  logic                 trig;        // Scan begins
  logic [11:0]          code_w;      // Clamped converter code
  logic [11:0]          val_w;       // Single or pair value
  logic [3:0]           rep_last;    // Final sample index of an average
  logic                 push_w;      // Sample completed, queued unless full
  logic [SAMPLE_W-1:0]  push_data;   // Sample pushed
  logic [SAMPLE_W-1:0]  mem_q [DEPTH]; // Queue storage
  logic [FIFO_AW-1:0]   wr_ptr_q;    // Queue write index
  logic [FIFO_AW-1:0]   rd_ptr_q;    // Queue read index
  logic [FIFO_AW:0]     count_q;     // Queue occupancy
  logic                 full_w;      // Queue full
  logic                 empty_w;     // Queue empty
  logic                 pop_w;       // Host drains one sample
  logic                 ovf_q;       // Sticky overflow flag
  logic [4:0]           thresh_q;    // Chunk level
  logic [NUM_LINES-1:0] sync1_q;     // Line synchroniser, first stage
  logic [NUM_LINES-1:0] sync2_q;     // Line synchroniser, second stage
  logic [3:0]           line_sel_q;  // Line chosen for single reads
  logic [9:0]           periph_q;    // Peripheral control bits
  logic [11:0]          rail_raw_q;  // Last rail reading
  logic [1:0]           rail_q;      // Rail of that reading
  logic [12:0]          scale_w;     // Factor of that rail
  logic [24:0]          rail_scaled; // Reading times factor

  // Bus slave: one wait cycle on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign do_wr = avs_write & ack_q;
  assign do_rd = avs_read & ack_q;
  assign avs_readdata = rdata_q;

  // Acknowledge phase toggles for a held request
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Read multiplexer, function chosen by the address
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      A_CTRL:   rd_mux[15:0] = ctrl_q;
      A_STAT:   rd_mux[7:0]  = {count_q, ovf_q, chunk_ready,
                                state_q != S_IDLE};
      A_FIFO:   rd_mux[15:0] = empty_w ? 16'h0000 : mem_q[rd_ptr_q];
      A_DAC0:   rd_mux[11:0] = dac0_code;
      A_DAC1:   rd_mux[11:0] = dac1_code;
      A_DIR:    rd_mux[12:0] = gpio_oe;
      A_OUT:    rd_mux[12:0] = gpio_out;
      A_IN:     rd_mux[12:0] = sync2_q;
      A_LINE:   rd_mux[0]    = sync2_q[line_sel_q];
      A_PERIPH: rd_mux[9:0]  = periph_q;
      A_SUPPLY: rd_mux[24:0] = rail_scaled;
      A_TEMP:   rd_mux[7:0]  = temp_c;
      A_THRESH: rd_mux[4:0]  = thresh_q;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Conversion control and the pending request
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 16'h0000;
      go_q   <= 1'b0;
    end else begin
      if (do_wr && avs_address == A_CTRL) begin
        ctrl_q <= avs_writedata[15:0];
      end
      // A new request wins over the consumption of the old one
      if (do_wr && avs_address == A_CTRL && avs_writedata[CTRL_GO]) begin
        go_q <= 1'b1;
      end else if (trig) begin
        go_q <= 1'b0;
      end
    end
  end

  // Analog output codes, full 12-bit range
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dac0_code <= 12'h000;
      dac1_code <= 12'h000;
    end else if (do_wr) begin
      if (avs_address == A_DAC0) begin
        dac0_code <= avs_writedata[11:0];
      end
      if (avs_address == A_DAC1) begin
        dac1_code <= avs_writedata[11:0];
      end
    end
  end

  // Line pins pass two flip-flops before use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= gpio_in;
      sync2_q <= sync1_q;
    end
  end

  // Line directions and levels; all inputs after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gpio_oe    <= '0;
      gpio_out   <= '0;
      line_sel_q <= 4'h0;
    end else if (do_wr) begin
      if (avs_address == A_DIR) begin
        gpio_oe <= avs_writedata[NUM_LINES-1:0];
      end
      if (avs_address == A_OUT) begin
        gpio_out <= avs_writedata[NUM_LINES-1:0];
      end
      // Single line: index selects, level bit is driven
      if (avs_address == A_LINE && avs_writedata[3:0] < 4'(NUM_LINES)) begin
        line_sel_q <= avs_writedata[3:0];
        gpio_out[avs_writedata[3:0]] <= avs_writedata[LINE_VAL];
      end
    end
  end

  // Board controls; 1.2 V camera enable idles high, which is off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      periph_q <= PERIPH_RST;
    end else if (do_wr && avs_address == A_PERIPH) begin
      periph_q <= avs_writedata[9:0];
    end
  end

  assign led_on      = periph_q[0];
  assign fan_en      = periph_q[1];
  assign modem_en    = periph_q[2];
  assign disp5v_en   = periph_q[3];
  assign cam12_en_n  = periph_q[4];
  assign cam18_en    = periph_q[5];
  assign cam28_en    = periph_q[6];
  assign serial_cfg  = periph_q[8:7];
  assign serial_slew = periph_q[9];

  // Clamp the converter word to a 12-bit code
  assign code_w = (conv_data > CODE_MAX) ? CODE_MAX[11:0]
                                         : conv_data[11:0];
  // Pair value is high minus low, never below zero
  assign val_w = !diff_q ? code_w
               : (hi_q > code_w) ? 12'(hi_q - code_w)
               : 12'h000;
  assign rep_last = 4'((5'h01 << avg_q) - 5'h01);
  assign trig = (state_q == S_IDLE) && (go_q || cont_q)
                && (rate_q == '0);
  assign conv_start = (state_q == S_CONV);
  // Pairs map low to the even channel, high to the odd one
  assign conv_chan = diff_q ? {chan_q[2:0], ~ph_lo_q} : chan_q;
  assign push_w = (state_q == S_WAIT) && conv_done
                  && !(diff_q && !ph_lo_q) && (rep_q == rep_last);
  assign push_data = acc_q + SAMPLE_W'(val_w);

  // Sequencer: single, scan, pair and averaging
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      diff_q  <= 1'b0;
      cont_q  <= 1'b0;
      chan_q  <= 4'h0;
      last_q  <= 4'h0;
      avg_q   <= 3'h0;
      rep_q   <= 4'h0;
      ph_lo_q <= 1'b0;
      hi_q    <= 12'h000;
      acc_q   <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          cont_q <= ctrl_q[CTRL_CONT];
          if (trig) begin
            diff_q  <= ctrl_q[CTRL_DIFF];
            chan_q  <= ctrl_q[CTRL_FIRST +: 4];
            // Single mode converts only the first channel
            last_q  <= ctrl_q[CTRL_SCAN] ? ctrl_q[CTRL_LAST +: 4]
                                         : ctrl_q[CTRL_FIRST +: 4];
            avg_q   <= (ctrl_q[CTRL_AVG +: 3] > AVG_MAX) ? AVG_MAX
                                         : ctrl_q[CTRL_AVG +: 3];
            rep_q   <= 4'h0;
            ph_lo_q <= 1'b0;
            acc_q   <= '0;
            state_q <= S_GAP;
          end
        end
        S_GAP: begin
          if (gap_q == 5'h00) begin
            state_q <= S_CONV;
          end
        end
        S_CONV: begin
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (conv_done) begin
            state_q <= S_GAP;
            if (diff_q && !ph_lo_q) begin
              hi_q    <= code_w;
              ph_lo_q <= 1'b1;
            end else begin
              ph_lo_q <= 1'b0;
              if (rep_q != rep_last) begin
                rep_q <= rep_q + 4'h1;
                acc_q <= push_data;
              end else begin
                rep_q <= 4'h0;
                acc_q <= '0;
                if (chan_q >= last_q) begin
                  state_q <= S_IDLE;
                end else begin
                  chan_q <= chan_q + 4'h1;
                end
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Spacing between conversion starts and between scans
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= 5'h00;
      rate_q <= '0;
    end else begin
      if (conv_start) begin
        gap_q <= 5'(SAMPLE_CYC - 1);
      end else if (gap_q != 5'h00) begin
        gap_q <= gap_q - 5'h01;
      end
      if (trig) begin
        rate_q <= RATE_W'(RATE_CYC - 1);
      end else if (rate_q != '0) begin
        rate_q <= rate_q - 1'b1;
      end
    end
  end

  // Last rail reading kept for the scaled view
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rail_raw_q <= 12'h000;
      rail_q     <= 2'h0;
    end else if (push_w && !diff_q && chan_q >= SUPPLY_BASE
                 && avg_q == 3'h0) begin
      rail_raw_q <= code_w;
      rail_q     <= 2'(chan_q - SUPPLY_BASE);
    end
  end

  // Factor per rail, result in thousandths of a code
  always_comb begin
    unique case (rail_q)
      2'h0: scale_w = SCALE_5V0;
      2'h1: scale_w = SCALE_MAIN;
      2'h2: scale_w = SCALE_1V8;
      2'h3: scale_w = SCALE_3V3;
    endcase
  end
  assign rail_scaled = 25'(rail_raw_q * scale_w);

  // Sample queue: a full queue drops new samples and flags it
  assign full_w  = (count_q == 5'(DEPTH));
  assign empty_w = (count_q == 5'h00);
  assign pop_w   = do_rd && avs_address == A_FIFO && !empty_w;
  assign chunk_ready = (count_q >= thresh_q) && !empty_w;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= 5'h00;
    end else begin
      if (push_w && !full_w) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + 5'(push_w && !full_w) - 5'(pop_w);
    end
  end

  // Queue storage
  always_ff @(posedge clock) begin
    if (push_w && !full_w) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  // Overflow is sticky; a new drop wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_q    <= 1'b0;
      thresh_q <= THRESH_RST;
    end else begin
      if (push_w && full_w) begin
        ovf_q <= 1'b1;
      end else if (do_wr && avs_address == A_STAT && avs_writedata[2]) begin
        ovf_q <= 1'b0;
      end
      if (do_wr && avs_address == A_THRESH) begin
        thresh_q <= avs_writedata[4:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_bus_wait;
    (avs_read || avs_write) && !ack_q |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait wrong");

  property p_dir_write;
    do_wr && avs_address == A_DIR |=> gpio_oe == $past(avs_writedata[12:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("dir lost");

  property p_dir_reset;
    $rose(rstn) |-> gpio_oe == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir reset");

  property p_clamp;
    push_w && !diff_q && avg_q == 3'h0 |-> push_data <= 16'h0FFF;
  endproperty
  a_clamp: assert property (p_clamp) else $error("code above 4095");

  property p_pair_floor;
    state_q == S_WAIT && conv_done && diff_q && ph_lo_q && code_w >= hi_q
      |-> val_w == 12'h000;
  endproperty
  a_pair_floor: assert property (p_pair_floor) else $error("neg pair");

  property p_spacing;
    conv_start |=> gap_q == 5'(SAMPLE_CYC - 1) ##1 !conv_start[*8];
  endproperty
  a_spacing: assert property (p_spacing) else $error("starts too close");

  property p_overflow;
    push_w && full_w |=> ovf_q && wr_ptr_q == $past(wr_ptr_q);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overwrite");

  property p_rate;
    trig |=> rate_q == RATE_W'(RATE_CYC - 1) ##1 !trig;
  endproperty
  a_rate: assert property (p_rate) else $error("rate limit");

  property p_dac;
    do_wr && avs_address == A_DAC1 |=> dac1_code == $past(avs_writedata[11:0]);
  endproperty
  a_dac: assert property (p_dac) else $error("dac not set");

  c_push: cover property (push_w && !full_w);
  c_drop: cover property (push_w && full_w);
  c_pair: cover property (state_q == S_WAIT && conv_done && diff_q);
  c_chunk: cover property ($rose(chunk_ready));

endmodule

// ==== dv/dcgc_conv_model.sv ====
// Converter model: answers each start after a short or a long delay
`timescale 1ns/100ps
module dcgc_conv_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_chan,
  output logic             conv_done,
  output logic      [12:0] conv_data
);
  logic [4:0]  cnt_q;   // Cycles left to the answer
  logic        slow_q;  // Alternates prompt and slow answers
  logic [3:0]  chan_q;  // Channel latched at start
  logic [12:0] val;     // Raw level of the latched channel
  // Fixed raw levels, one above full scale to exercise the clamp
  always_comb begin
    case (chan_q)
      4'h0:    val = 13'h0200;
      4'h1:    val = 13'h0150;
      4'h2:    val = 13'h0100;
      4'h3:    val = 13'h0300;
      4'h4:    val = 13'h1FFF;
      default: val = 13'h0010;
    endcase
  end
  // One done pulse per start; data toggles while not valid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {cnt_q, slow_q, chan_q, conv_done, conv_data} <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        chan_q <= conv_chan;
        cnt_q  <= slow_q ? 5'd12 : 5'd3;
        slow_q <= !slow_q;
      end else if (cnt_q != 5'd0) begin
        cnt_q <= cnt_q - 5'd1;
        if (cnt_q == 5'd1) begin
          conv_done <= 1'b1;
          conv_data <= val;
        end
      end
    end
  end
endmodule

// ==== dv/dcgc_top_tb_top.sv ====
// Bench for the acquisition controller: registers, lines, conversions
`timescale 1ns/100ps
module dcgc_top_tb_top;
  import dcgc_pkg::*;
  logic        clock, rstn, avs_read, avs_write, avs_waitrequest;
  logic        conv_start, conv_done, chunk_ready;
  logic        led_on, fan_en, modem_en, disp5v_en, cam12_en_n;
  logic        cam18_en, cam28_en, serial_slew;
  logic [1:0]  serial_cfg;
  logic [3:0]  conv_chan;
  logic [7:0]  avs_address, temp_c;
  logic [11:0] dac0_code, dac1_code;
  logic [12:0] conv_data, gpio_in, gpio_out, gpio_oe;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          errors, n_tests;
  dcgc_top #(.RATE_CYC(50)) dut_u (.clock, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .conv_start, .conv_chan, .conv_done, .conv_data, .dac0_code,
    .dac1_code, .gpio_in, .gpio_out, .gpio_oe, .temp_c, .led_on, .fan_en,
    .modem_en, .disp5v_en, .cam12_en_n, .cam18_en, .cam28_en, .serial_cfg,
    .serial_slew, .chunk_ready);
  dcgc_conv_model conv_u (.clock, .rstn, .conv_start, .conv_chan,
    .conv_done, .conv_data);
  // Verdict and end of run
  task automatic stop_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
      errors++;
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      errors++;
      stop_test();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(q, exp);
  endtask
  // Read a register until the masked bits match, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, '0);
      k++;
    end while ((q & m) !== v && k < 600);
    if (k >= 600) begin
      errors++;
      stop_test();
    end
  endtask
  // Start a conversion and wait until n samples are queued
  task automatic run(input logic [31:0] ctrl, input logic [4:0] n);
    bus(1'b1, A_CTRL, ctrl);
    poll(A_STAT, 32'h0000_00F8, {24'h0, n, 3'h0});
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {errors, n_tests} = '0;
    gpio_in = 13'h1A5C;
    temp_c = 8'h2A;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk({22'h0, serial_slew, serial_cfg, cam28_en, cam18_en, cam12_en_n,
         disp5v_en, modem_en, fan_en, led_on}, 32'h0000_0010);
    chk({19'h0, gpio_oe}, 32'h0000_0000);
    rdchk(A_DIR, 32'h0000_0000);
    rdchk(8'h3C, 32'h0000_0000);
    rdchk(A_TEMP, 32'h0000_002A);
    bus(1'b1, A_PERIPH, 32'h0000_03EF);
    chk({22'h0, serial_slew, serial_cfg, cam28_en, cam18_en, cam12_en_n,
         disp5v_en, modem_en, fan_en, led_on}, 32'h0000_03EF);
    bus(1'b1, A_DAC0, 32'h0000_0FFF);
    bus(1'b1, A_DAC1, 32'h0000_0800);
    chk({8'h0, dac1_code, dac0_code}, 32'h0080_0FFF);
    bus(1'b1, A_DIR, 32'h0000_0201);
    bus(1'b1, A_OUT, 32'h0000_0001);
    bus(1'b1, A_LINE, 32'h0000_0109);
    chk({3'h0, gpio_oe, 3'h0, gpio_out}, 32'h0201_0201);
    rdchk(A_IN, 32'h0000_1A5C);
    bus(1'b1, A_LINE, 32'h0000_0003);
    rdchk(A_LINE, 32'h0000_0001);
    run(32'h0000_0041, 5'd1);
    rdchk(A_FIFO, 32'h0000_0FFF);
    run(32'h0000_0425, 5'd3);
    rdchk(A_FIFO, 32'h0000_0100);
    rdchk(A_FIFO, 32'h0000_0300);
    rdchk(A_FIFO, 32'h0000_0FFF);
    run(32'h0000_0003, 5'd1);
    rdchk(A_FIFO, 32'h0000_0000);
    run(32'h0000_0013, 5'd1);
    rdchk(A_FIFO, 32'h0000_0200);
    run(32'h0000_1031, 5'd1);
    rdchk(A_FIFO, 32'h0000_0600);
    run(32'h0000_0071, 5'd1);
    rdchk(A_FIFO, 32'h0000_0010);
    rdchk(A_SUPPLY, 32'h0001_5950);
    // Continuous scans fill the queue; later samples are dropped
    bus(1'b1, A_CTRL, 32'h0000_0028);
    poll(A_STAT, 32'h0000_0004, 32'h0000_0004);
    bus(1'b1, A_CTRL, 32'h0000_0000);
    poll(A_STAT, 32'h0000_0001, 32'h0000_0000);
    rdchk(A_STAT, 32'h0000_0086);
    chk({31'h0, chunk_ready}, 32'h0000_0001);
    bus(1'b1, A_STAT, 32'h0000_0004);
    rdchk(A_FIFO, 32'h0000_0100);
    rdchk(A_STAT, 32'h0000_007A);
    stop_test();
  end
endmodule
